// ===== inc/arci_pkg.sv
package arci_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ARCI_OFF_RESULT_HIGH = 8'h00;
  localparam logic [7:0] ARCI_OFF_RESULT_LOW = 8'h04;
  localparam logic [7:0] ARCI_OFF_CLOCK_CFG = 8'h08;
  localparam logic [7:0] ARCI_OFF_MODE = 8'h0C;
  localparam logic [7:0] ARCI_OFF_STATUS = 8'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ARCI_CLK_LOW_POWER_BIT = 7;
  localparam int ARCI_MODE_TEN_BIT = 0;
  localparam int ARCI_STAT_LOCKED_BIT = 0;
  localparam int ARCI_STAT_LOST_BIT = 1;

  // ----------------------------------------
  // reset values and widths
  // ----------------------------------------
  localparam logic [7:0] ARCI_CLOCK_CFG_RESET = 8'h00;
  localparam logic [7:0] ARCI_MODE_RESET = 8'h00;
  localparam int ARCI_RESULT_WIDTH = 10;
  localparam int ARCI_FULL_CODES = 1024;

  localparam logic [1:0] ARCI_RESP_OKAY = 2'h0;
  localparam logic [1:0] ARCI_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic valid;
    logic [ARCI_RESULT_WIDTH-1:0] code;
  } arci_conv_type;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } arci_result_type;

endpackage

// ===== rtl/arci_hold_reg.sv
module arci_hold_reg
  import arci_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout <= '0;
    end else if (load) begin
      dout <= din;
    end
  end

endmodule

// ===== rtl/arci_result_lock.sv
module arci_result_lock
  import arci_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ten_bit,
  input wire logic conv_done,
  input wire logic read_high,
  input wire logic read_low,
  output logic load,
  output logic locked,
  output logic lost
);

  logic locked_r;

  assign locked = locked_r;
  assign load = conv_done && !(ten_bit && locked_r);
  assign lost = conv_done && ten_bit && locked_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locked_r <= 1'b0;
    end else if (read_low || !ten_bit) begin
      locked_r <= 1'b0;
    end else if (read_high) begin
      locked_r <= 1'b1;
    end
  end

endmodule

// ===== rtl/arci_top.sv
module arci_top
  import arci_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CONV_DONE,
  input wire logic [ARCI_RESULT_WIDTH-1:0] CONV_CODE,
  output logic [7:0] CLOCK_CFG,
  output logic LOW_POWER,
  output logic TEN_BIT_MODE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // ----------------------------------------
  // signals
  // ----------------------------------------
  arci_conv_type conv;
  arci_result_type result;
  logic [ARCI_RESULT_WIDTH-1:0] held_code;
  logic [7:0] clock_cfg_r;
  logic [7:0] mode_r;
  logic lost_r;
  logic load;
  logic locked;
  logic lost;
  logic ten_bit;
  logic aw_have_r;
  logic [7:0] aw_addr_r;
  logic w_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;
  logic do_read;
  logic read_high;
  logic read_low;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;

  assign conv = '{valid: CONV_DONE, code: CONV_CODE};
  assign ten_bit = mode_r[ARCI_MODE_TEN_BIT];

  // ----------------------------------------
  // result interlock and storage
  // ----------------------------------------
  // lock only in 10-bit mode
  arci_result_lock u_lock (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .ten_bit(ten_bit),
    .conv_done(conv.valid),
    .read_high(read_high),
    .read_low(read_low),
    .load(load),
    .locked(locked),
    .lost(lost)
  );

  arci_hold_reg #(
    .WIDTH(ARCI_RESULT_WIDTH)
  ) u_hold (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .load(load),
    .din(conv.code),
    .dout(held_code)
  );

  always_comb begin
    result.low = held_code[7:0];
    result.high = 8'h00;
    if (ten_bit) begin
      result.high = {6'h00, held_code[ARCI_RESULT_WIDTH-1:8]};
    end
  end

  // sticky lost-result flag, set wins over clear
  // record discarded result
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lost_r <= 1'b0;
    end else if (lost) begin
      lost_r <= 1'b1;
    end else if (read_low) begin
      lost_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // write channel
  // ----------------------------------------
  assign do_write = aw_have_r && w_have_r && !S_AXI_BVALID;

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      S_AXI_AWREADY <= 1'b0;
    end else if (do_write) begin
      aw_have_r <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_r <= 1'b1;
      aw_addr_r <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else begin
      S_AXI_AWREADY <= !aw_have_r && !S_AXI_BVALID;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      S_AXI_WREADY <= 1'b0;
    end else if (do_write) begin
      w_have_r <= 1'b0;
      S_AXI_WREADY <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_r <= 1'b1;
      w_data_r <= S_AXI_WDATA;
      w_strb_r <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else begin
      S_AXI_WREADY <= !w_have_r && !S_AXI_BVALID;
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= ARCI_RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      if (aw_addr_r[7:2] == ARCI_OFF_CLOCK_CFG[7:2] || aw_addr_r[7:2] == ARCI_OFF_MODE[7:2]) begin
        S_AXI_BRESP <= ARCI_RESP_OKAY;
      end else begin
        S_AXI_BRESP <= ARCI_RESP_SLVERR;
      end
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // software clock settings
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      clock_cfg_r <= ARCI_CLOCK_CFG_RESET;
    end else if (do_write && w_strb_r[0] && aw_addr_r[7:2] == ARCI_OFF_CLOCK_CFG[7:2]) begin
      clock_cfg_r <= w_data_r[7:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_r <= ARCI_MODE_RESET;
    end else if (do_write && w_strb_r[0] && aw_addr_r[7:2] == ARCI_OFF_MODE[7:2]) begin
      mode_r <= {7'h00, w_data_r[ARCI_MODE_TEN_BIT]};
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CLOCK_CFG <= ARCI_CLOCK_CFG_RESET;
      LOW_POWER <= 1'b0;
      TEN_BIT_MODE <= 1'b0;
    end else begin
      CLOCK_CFG <= clock_cfg_r;
      LOW_POWER <= clock_cfg_r[ARCI_CLK_LOW_POWER_BIT];
      TEN_BIT_MODE <= ten_bit;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign do_read = S_AXI_ARVALID && S_AXI_ARREADY;
  assign read_high = do_read && S_AXI_ARADDR[7:2] == ARCI_OFF_RESULT_HIGH[7:2];
  assign read_low = do_read && S_AXI_ARADDR[7:2] == ARCI_OFF_RESULT_LOW[7:2];

  always_comb begin
    rdata_nxt = 32'h00000000;
    rresp_nxt = ARCI_RESP_OKAY;
    case (S_AXI_ARADDR[7:2])
      ARCI_OFF_RESULT_HIGH[7:2]: rdata_nxt[7:0] = result.high;
      ARCI_OFF_RESULT_LOW[7:2]: rdata_nxt[7:0] = result.low;
      ARCI_OFF_CLOCK_CFG[7:2]: rdata_nxt[7:0] = clock_cfg_r;
      ARCI_OFF_MODE[7:2]: rdata_nxt[7:0] = mode_r;
      ARCI_OFF_STATUS[7:2]: begin
        rdata_nxt[ARCI_STAT_LOCKED_BIT] = locked;
        rdata_nxt[ARCI_STAT_LOST_BIT] = lost_r;
      end
      default: rresp_nxt = ARCI_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= ARCI_RESP_OKAY;
    end else if (do_read) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rdata_nxt;
      S_AXI_RRESP <= rresp_nxt;
    end else if (S_AXI_RVALID) begin
      if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end else begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule

// ===== dv/arci_monitor.sv
module arci_monitor
  import arci_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic CONV_DONE,
  input wire logic [ARCI_RESULT_WIDTH-1:0] CONV_CODE,
  input wire logic [7:0] CLOCK_CFG,
  input wire logic TEN_BIT_MODE,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  logic ar_hs;
  logic lock_r;
  logic lost_r;
  logic [9:0] res_r;
  assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lock_r <= 1'b0;
    end else if (!TEN_BIT_MODE || (ar_hs && S_AXI_ARADDR == ARCI_OFF_RESULT_LOW)) begin
      lock_r <= 1'b0;
    end else if (ar_hs && S_AXI_ARADDR == ARCI_OFF_RESULT_HIGH) begin
      lock_r <= 1'b1;
    end
  end
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      res_r <= 10'h0;
    end else if (CONV_DONE && !lock_r) begin
      res_r <= CONV_CODE;
    end
  end
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lost_r <= 1'b0;
    end else if (CONV_DONE && lock_r) begin
      lost_r <= 1'b1;
    end else if (ar_hs && S_AXI_ARADDR == ARCI_OFF_RESULT_LOW) begin
      lost_r <= 1'b0;
    end
  end
  property p_low;
    ar_hs && S_AXI_ARADDR == ARCI_OFF_RESULT_LOW |=> S_AXI_RDATA == {24'h0, $past(res_r[7:0])};
  endproperty
  a_low: assert property (p_low) else $error("low byte mismatch");
  property p_high;
    ar_hs && S_AXI_ARADDR == ARCI_OFF_RESULT_HIGH |=>
      S_AXI_RDATA == ($past(TEN_BIT_MODE) ? {30'h0, $past(res_r[9:8])} : 32'h0);
  endproperty
  a_high: assert property (p_high) else $error("high byte mismatch");
  property p_lock;
    ar_hs && S_AXI_ARADDR == ARCI_OFF_STATUS |=> S_AXI_RDATA[0] == $past(lock_r);
  endproperty
  a_lock: assert property (p_lock) else $error("lock state mismatch");
  property p_lost;
    ar_hs && S_AXI_ARADDR == ARCI_OFF_STATUS |=> S_AXI_RDATA[1] == $past(lost_r);
  endproperty
  a_lost: assert property (p_lost) else $error("lost flag mismatch");
  property p_cfg;
    ar_hs && S_AXI_ARADDR == ARCI_OFF_CLOCK_CFG |=> S_AXI_RDATA == {24'h0, CLOCK_CFG};
  endproperty
  a_cfg: assert property (p_cfg) else $error("clock config mismatch");
  property p_width;
    S_AXI_RVALID |-> S_AXI_RDATA[31:10] == 22'h0;
  endproperty
  a_width: assert property (p_width) else $error("read data too wide");
  property p_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_hold: assert property (p_hold) else $error("read data not held");
  property p_one_rd;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_one_rd: assert property (p_one_rd) else $error("read taken while pending");
endmodule
bind arci_top arci_monitor i_mon (.REF_CLK, .SYS_RST, .CONV_DONE, .CONV_CODE, .CLOCK_CFG,
  .TEN_BIT_MODE, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
  .S_AXI_RVALID, .S_AXI_RREADY);

// ===== dv/testbench.sv
module testbench
  import arci_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, done, lp, ten, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [9:0] code;
  logic [7:0] cfg, awa, ara;
  logic [31:0] wd, rd_d, dat;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] ws;
  int rr_wait = 0;
  logic [7:0] cv_t [2] = '{8'hA5, 8'h5A};
  int failures = 0;
  int cmp_count = 0;
  arci_top i_dut (.REF_CLK(clk), .SYS_RST(rst), .CONV_DONE(done), .CONV_CODE(code),
    .CLOCK_CFG(cfg), .LOW_POWER(lp), .TEN_BIT_MODE(ten), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd_d), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    r = bresp;
    br <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= (rr_wait == 0);
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
      if (n == rr_wait) rr <= 1'b1;
    end while (!(rv && rr));
    d = rd_d;
    r = rresp;
    rr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, dat, rsp);
    chk(dat, e);
  endtask
  task automatic conv(input logic [9:0] c);
    @(posedge clk);
    done <= 1'b1;
    code <= c;
    @(posedge clk);
    done <= 1'b0;
  endtask
  task automatic results;
    $display("failures=%0d compares=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
  // ----
  // main sequence
  // ----
  initial begin
    rst = 1'b1;
    done = 1'b0;
    code = 10'h0;
    awa = 8'h0;
    ara = 8'h0;
    wd = 32'h0;
    ws = 4'hF;
    awv = 1'b0;
    wv = 1'b0;
    br = 1'b0;
    arv = 1'b0;
    rr = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(ARCI_OFF_CLOCK_CFG, 32'h0);
    rc(ARCI_OFF_MODE, 32'h0);
    foreach (cv_t[i]) begin
      wr(ARCI_OFF_CLOCK_CFG, {24'h0, cv_t[i]}, rsp);
      chk({30'h0, rsp}, {30'h0, ARCI_RESP_OKAY});
      rc(ARCI_OFF_CLOCK_CFG, {24'h0, cv_t[i]});
      chk({31'h0, lp}, {31'h0, cv_t[i][7]});
      chk({24'h0, cfg}, {24'h0, cv_t[i]});
    end
    ws <= 4'h0;
    wr(ARCI_OFF_CLOCK_CFG, 32'hFF, rsp);
    chk({30'h0, rsp}, {30'h0, ARCI_RESP_OKAY});
    rc(ARCI_OFF_CLOCK_CFG, {24'h0, cv_t[1]});
    ws <= 4'hF;
    conv(10'h0C3);
    rc(ARCI_OFF_RESULT_HIGH, 32'h0);
    conv(10'h07E);
    rc(ARCI_OFF_RESULT_LOW, 32'h7E);
    wr(ARCI_OFF_MODE, 32'h1, rsp);
    conv(10'h2B7);
    chk({31'h0, ten}, 32'h1);
    rc(ARCI_OFF_RESULT_HIGH, 32'h2);
    conv(10'h155);
    rc(ARCI_OFF_STATUS, 32'h3);
    rc(ARCI_OFF_RESULT_LOW, 32'hB7);
    rc(ARCI_OFF_STATUS, 32'h0);
    conv(10'h3FF);
    rc(ARCI_OFF_RESULT_HIGH, 32'h3);
    rc(ARCI_OFF_RESULT_LOW, 32'hFF);
    rc(ARCI_OFF_RESULT_HIGH, 32'h3);
    wr(ARCI_OFF_MODE, 32'h0, rsp);
    conv(10'h042);
    chk({31'h0, ten}, 32'h0);
    rc(ARCI_OFF_RESULT_LOW, 32'h42);
    wr(ARCI_OFF_RESULT_LOW, 32'h11, rsp);
    chk({30'h0, rsp}, {30'h0, ARCI_RESP_SLVERR});
    rc(ARCI_OFF_RESULT_LOW, 32'h42);
    rr_wait = 3;
    rc(ARCI_OFF_RESULT_LOW, 32'h42);
    rr_wait = 0;
    rd(8'h20, dat, rsp);
    chk({30'h0, rsp}, {30'h0, ARCI_RESP_SLVERR});
    results();
  end
endmodule
